/* File: sirq_consts.svh */
// Purpose: Constants for the serialized interrupt host controller.
// Assumes: One clock, the bus clock of the serial interrupt line.
// Notes: Counts are in clocks of that bus clock.
//
// Contract
// RULE_01 - Quiet idle: agent pulls low one clock
// RULE_02 - No start frame while cycle runs
// RULE_03 - Host holds low 3-7 more, drives high
// RULE_04 - Slave starts frame on input change
// RULE_05 - Continuous mode: only host opens start
// RULE_06 - Host may idle or restart after stop
// RULE_07 - Mode changes in stop; reset is continuous
// RULE_08 - Stop width: two quiet, three continuous
// RULE_09 - Next start two clocks after stop rise
// RULE_10 - Only host drives stop frames
// RULE_11 - Slaves count three-clock data frames
// RULE_12 - Slave pulls low in sample if low
// RULE_13 - Slave drives high in recovery after low
// RULE_14 - Slave releases in turn-around, always reports
// RULE_15 - Slot n samples 3n-1 clocks after rise
// RULE_16 - Slot 3 irq2 or sysmgmt, slot 14 irq13
// RULE_17 - Enable bits route sysmgmt to slot/pin
// RULE_18 - Drive and sample on rising clock edge
// RULE_19 - Bus reset releases line, continuous mode
// RULE_20 - Host runs first cycle, defaults before it
// RULE_21 - Host runs at least seventeen data frames
// RULE_22 - Delay end-of-interrupt by cycle latency
// RULE_23 - Stop pulse two or three clocks long
// RULE_24 - Slaves silent in slot 1, beyond 16
`ifndef SIRQ_CONSTS_SVH
`define SIRQ_CONSTS_SVH

`define SIRQ_EXTRA_MIN 3'h3
`define SIRQ_EXTRA_MAX 3'h7
`define SIRQ_FRAMES_MIN 6'h11
`define SIRQ_FRAME_W 6
`define SIRQ_SLOTS 16
`define SIRQ_LAST_SLOT 6'h10
`define SIRQ_STOP_QUIET_CNT 3'h1
`define SIRQ_STOP_CONT_CNT 3'h2
`define SIRQ_LEVELS_RESET 16'hFFFF

`endif

/* File: sirq_pkg.sv */
// Purpose: Types for the serialized interrupt host controller.
// Assumes: Constants header is on the include path.
// Notes: None.
`include "sirq_consts.svh"

package sirq_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_START_HI,
        ST_FRAMES,
        ST_STOP,
        ST_STOP_HI,
        ST_TURN
    } sirq_state_t;

    typedef struct packed {
        sirq_state_t state;
        logic [2:0] lowCnt;
        logic [1:0] phase;
        logic [`SIRQ_FRAME_W-1:0] frame;
        logic [`SIRQ_SLOTS-1:0] levels;
        logic lineOut;
        logic lineOe;
        logic levelsValid;
        logic busy;
        logic quiet;
        logic firstDone;
    } sirq_regs_t;

endpackage : sirq_pkg

/* File: sirq_host.sv */
// Purpose: Host end of the serialized interrupt line.
// Assumes: Line is synchronous to clock, pulled up outside.
// Notes: Line drive is a registered output with enable.
// Notes: Line input is same-clock logic, so it takes no synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "sirq_consts.svh"

module sirq_host (
    input wire logic clock,
    input wire logic nrst,
    input wire logic serIrqIn,
    output logic serIrqOut,
    output logic serIrqOe,
    input wire logic startRequest,
    input wire logic quietEnable,
    input wire logic [2:0] startExtra,
    input wire logic [`SIRQ_FRAME_W-1:0] frameCount,
    output logic [`SIRQ_SLOTS-1:0] irqLevels,
    output logic levelsValid,
    output logic cycleBusy,
    output logic quietActive
);

    // ********************************************************
    // State
    // ********************************************************
    sirq_pkg::sirq_regs_t s;
    sirq_pkg::sirq_regs_t next_s;
    logic [2:0] extra;
    logic [`SIRQ_FRAME_W-1:0] frames;
    logic [3:0] slotIdx;

    localparam sirq_pkg::sirq_regs_t RESET_REGS = '{
        state: sirq_pkg::ST_IDLE,
        lowCnt: 3'h0,
        phase: 2'h0,
        frame: '0,
        levels: `SIRQ_LEVELS_RESET,
        lineOut: 1'b1,
        lineOe: 1'b0,
        levelsValid: 1'b0,
        busy: 1'b0,
        quiet: 1'b0,
        firstDone: 1'b0
    };

    // ********************************************************
    // Settings clamp
    // ********************************************************
    // Below-minimum settings would shorten the start or the cycle
    always_comb
    begin
        extra = startExtra;
        if (startExtra < `SIRQ_EXTRA_MIN)
        begin
            extra = `SIRQ_EXTRA_MIN; // RULE_03
        end
        frames = frameCount;
        if (frameCount < `SIRQ_FRAMES_MIN)
        begin
            frames = `SIRQ_FRAMES_MIN; // RULE_21
        end
        slotIdx = 4'(s.frame - 6'h01);
    end

    // ********************************************************
    // Frame decode
    // ********************************************************
    logic lastFrame;
    logic slotInRange;
    always_comb
    begin
        lastFrame = (s.frame == frames);
        slotInRange = (s.frame >= 6'h02) && (s.frame <= `SIRQ_LAST_SLOT);
    end

    // ********************************************************
    // Cycle sequencer
    // ********************************************************
    always_comb
    begin
        next_s = s;
        next_s.levelsValid = 1'b0;
        unique case (s.state)
            sirq_pkg::ST_IDLE:
            begin
                next_s.lineOe = 1'b0;
                if (!s.firstDone || startRequest)
                begin
                    // Host opens in either mode
                    next_s.state = sirq_pkg::ST_START; // RULE_05 RULE_06 RULE_20
                    next_s.lineOe = 1'b1;
                    next_s.lineOut = 1'b0;
                    next_s.lowCnt = extra;
                end
                else if (s.quiet && !serIrqIn)
                begin
                    // Raw line: a one-clock slave pulse must not be lost
                    // Slave pulled low one clock; take over next clock
                    next_s.state = sirq_pkg::ST_START; // RULE_01
                    next_s.lineOe = 1'b1;
                    next_s.lineOut = 1'b0;
                    next_s.lowCnt = 3'(extra - 3'h1); // RULE_03
                end
            end
            sirq_pkg::ST_START:
            begin
                // Count down the remaining low clocks
                if (s.lowCnt == 3'h0)
                begin
                    next_s.state = sirq_pkg::ST_START_HI;
                    next_s.lineOut = 1'b1; // RULE_03
                end
                else
                begin
                    next_s.lowCnt = 3'(s.lowCnt - 3'h1);
                end
            end
            sirq_pkg::ST_START_HI:
            begin
                // Rising edge of start pulse is clock 0
                next_s.state = sirq_pkg::ST_FRAMES;
                next_s.lineOe = 1'b0; // RULE_03
                next_s.phase = 2'h2;
                next_s.frame = '0;
                next_s.firstDone = 1'b1;
            end
            sirq_pkg::ST_FRAMES:
            begin
                unique case (s.phase)
                    2'h0:
                    begin
                        // Sample clock 3n-1 of slot n
                        if (slotInRange)
                        begin
                            next_s.levels[slotIdx] = serIrqIn; // RULE_15 RULE_16 RULE_18
                        end
                        next_s.phase = 2'h1;
                    end
                    2'h1:
                    begin
                        next_s.phase = 2'h2;
                    end
                    default:
                    begin
                        if (lastFrame)
                        begin
                            // Stop width carries next cycle's mode
                            next_s.state = sirq_pkg::ST_STOP; // RULE_10
                            next_s.lineOe = 1'b1;
                            next_s.lineOut = 1'b0;
                            next_s.quiet = quietEnable; // RULE_07
                            next_s.lowCnt = quietEnable ? `SIRQ_STOP_QUIET_CNT
                                                        : `SIRQ_STOP_CONT_CNT; // RULE_23
                        end
                        else
                        begin
                            next_s.phase = 2'h0;
                            next_s.frame = `SIRQ_FRAME_W'(s.frame + 6'h01);
                        end
                    end
                endcase
            end
            sirq_pkg::ST_STOP:
            begin
                if (s.lowCnt == 3'h0)
                begin
                    next_s.state = sirq_pkg::ST_STOP_HI;
                    next_s.lineOut = 1'b1;
                end
                else
                begin
                    next_s.lowCnt = 3'(s.lowCnt - 3'h1);
                end
            end
            sirq_pkg::ST_STOP_HI:
            begin
                // Release after one high clock; turn clock follows
                next_s.state = sirq_pkg::ST_TURN;
                next_s.lineOe = 1'b0;
            end
            sirq_pkg::ST_TURN:
            begin
                // Start may follow after one idle clock, no earlier
                next_s.state = sirq_pkg::ST_IDLE; // RULE_09 RULE_02
                next_s.levelsValid = 1'b1; // RULE_22
            end
            default:
            begin
                next_s = RESET_REGS;
            end
        endcase
        next_s.busy = (next_s.state != sirq_pkg::ST_IDLE);
    end

    // Synchronous reset also stands for the bus reset
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            s <= RESET_REGS; // RULE_19
        end
        else
        begin
            s <= next_s;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    // Every output is a register bit of the state
    assign serIrqOut = s.lineOut;
    assign serIrqOe = s.lineOe;
    assign irqLevels = s.levels;
    assign levelsValid = s.levelsValid;
    assign cycleBusy = s.busy;
    assign quietActive = s.quiet;

endmodule : sirq_host
`default_nettype wire

/* File: sirq_host_sva.sv */
// Purpose: Protocol assertions for the serial interrupt host.
// Assumes: Bound to the host top module.
// Notes: Low runs of the host drive are counted in helper logic.
`timescale 1ns/1ps
`default_nettype none
module sirq_host_sva (
    input wire logic clock,
    input wire logic nrst,
    input wire logic serIrqIn,
    input wire logic serIrqOut,
    input wire logic serIrqOe,
    input wire logic startRequest,
    input wire logic quietEnable,
    input wire logic [2:0] startExtra,
    input wire logic cycleBusy,
    input wire logic quietActive
);
    logic [3:0] lowCnt;
    logic isStart;
    logic bySlave;
    logic [3:0] ext;
    assign ext = (startExtra < 3'h3) ? 4'h3 : {1'b0, startExtra};
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!nrst);
    sequence hostHigh;
        serIrqOe && $rose(serIrqOut);
    endsequence
    always_ff @(posedge clock)
    begin
        lowCnt <= (serIrqOe && !serIrqOut) ? lowCnt + 4'h1 : 4'h0;
        if (serIrqOe && !serIrqOut && lowCnt == 4'h0)
        begin
            isStart <= !$past(cycleBusy);
            bySlave <= !$past(serIrqIn);
        end
    end
    a_reset_release: assert property (disable iff (1'b0) !nrst |=> !serIrqOe && !quietActive)
        else $error("Line driven or quiet during reset");
    a_first_cycle: assert property ($rose(nrst) |=> serIrqOe && !serIrqOut)
        else $error("No first cycle after reset");
    a_start_width: assert property (hostHigh |-> !isStart || lowCnt == ext + {3'h0, !bySlave})
        else $error("Start low width wrong");
    a_stop_width: assert property (hostHigh |-> isStart || lowCnt == (quietEnable ? 4'h2 : 4'h3))
        else $error("Stop low width wrong");
    a_high_release: assert property (hostHigh |=> !serIrqOe)
        else $error("High clock not followed by release");
    a_busy_start: assert property ($rose(cycleBusy) |-> serIrqOe && !serIrqOut)
        else $error("Cycle opened without start low");
    a_slave_start: assert property (!cycleBusy && quietActive && !serIrqIn |=> serIrqOe && !serIrqOut)
        else $error("Slave start not taken over");
    a_cont_passive: assert property (!cycleBusy && !quietActive && !startRequest && $past(nrst) |=> !serIrqOe)
        else $error("Start opened without request");
endmodule : sirq_host_sva
bind sirq_host sirq_host_sva u_sirq_host_sva (.clock(clock), .nrst(nrst), .serIrqIn(serIrqIn),
    .serIrqOut(serIrqOut), .serIrqOe(serIrqOe), .startRequest(startRequest),
    .quietEnable(quietEnable), .startExtra(startExtra), .cycleBusy(cycleBusy),
    .quietActive(quietActive));
`default_nettype wire

/* File: sirq_slave_model.sv */
// Purpose: Behavioural slave agent on the serial interrupt line.
// Assumes: Line is resolved outside with a pull-up.
// Notes: Bit 0 of irq has no slot but counts as an input change.
`timescale 1ns/1ps
`default_nettype none
module sirq_slave_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic line,
    input wire logic [15:0] irq,
    output logic drvOe,
    output logic drvOut
);
    logic [3:0] lowRun;
    logic [7:0] cnt;
    logic [1:0] gap;
    logic quiet;
    logic [15:0] sent;
    int k;
    always @(posedge clock)
    begin
        if (!nrst)
        begin
            {lowRun, cnt, gap, quiet, drvOe} <= '0;
            drvOut <= 1'b1;
            sent <= irq;
        end
        else
        begin
            k = (cnt != 8'h0) ? cnt + 1 : 0;
            if (line && lowRun >= 4'h4)
            begin
                k = 1;
                sent <= irq;
            end
            gap <= (gap != 2'h3) ? gap + 2'h1 : gap;
            if (line && lowRun inside {4'h2, 4'h3})
            begin
                k = 0;
                quiet <= (lowRun == 4'h2);
                gap <= 2'h0;
            end
            lowRun <= line ? 4'h0 : lowRun + 4'h1;
            cnt <= k[7:0];
            drvOut <= (k % 3 == 0);
            // Slot 3 takes irq[2], as if the slot routing enable were clear
            drvOe <= (k % 3 == 2 && k >= 5 && k <= 47 && !irq[(k + 1) / 3 - 1])
                || (k % 3 == 0 && k > 0 && drvOe && !drvOut);
            if (k == 0 && quiet && gap != 2'h0 && line && irq != sent)
            begin
                drvOe <= 1'b1;
                drvOut <= 1'b0;
            end
        end
    end
endmodule : sirq_slave_model
`default_nettype wire

/* File: sirq_host_bench.sv */
// Purpose: Self-checking bench for the serial interrupt host.
// Assumes: Slave model answers in the data frames.
// Notes: Rows hold mode, start extra, frame count and levels.
`timescale 1ns/1ps
`default_nettype none
module sirq_host_bench;
    logic clock = 0, nrst = 0, startRequest = 0, quietEnable = 0, tbLow = 0, q = 0;
    logic [2:0] startExtra = 3'h3;
    logic [5:0] frameCount = 6'h11;
    logic [15:0] irq = 16'hFFFF, irqLevels;
    logic hOe, hOut, sOe, sOut, line, levelsValid, cycleBusy, quietActive;
    int errCount = 0, samplesChecked = 0;
    logic [25:0] rows [6] = '{{1'b0, 3'h3, 6'h11, 16'h0000}, {1'b1, 3'h7, 6'h11, 16'h5555},
        {1'b0, 3'h5, 6'h14, 16'hAAAA}, {1'b1, 3'h4, 6'h11, 16'hFFFF},
        {1'b0, 3'h6, 6'h3F, 16'h7FFE}, {1'b0, 3'h1, 6'h05, 16'h8001}};
    assign line = !((hOe && !hOut) || (sOe && !sOut) || tbLow);
    always #50 clock = !clock;
    sirq_host u_sirq_host (.clock(clock), .nrst(nrst), .serIrqIn(line), .serIrqOut(hOut),
        .serIrqOe(hOe), .startRequest(startRequest), .quietEnable(quietEnable),
        .startExtra(startExtra), .frameCount(frameCount), .irqLevels(irqLevels),
        .levelsValid(levelsValid), .cycleBusy(cycleBusy), .quietActive(quietActive));
    sirq_slave_model u_sirq_slave_model (.clock(clock), .nrst(nrst), .line(line), .irq(irq),
        .drvOe(sOe), .drvOut(sOut));
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samplesChecked++;
        if (seen !== exp)
        begin
            errCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task waitValid;
        int i;
        i = 0;
        do
        begin
            @(posedge clock);
            i++;
        end
        while (levelsValid !== 1'b1 && i < 400);
        check({15'h0, levelsValid}, 16'h1, "levelsValid");
    endtask : waitValid
    // Separate tasks: a task argument would only be copied back on return
    task pulseStart;
        startRequest <= 1'b1;
        @(posedge clock);
        startRequest <= 1'b0;
    endtask : pulseStart
    task pulseLow;
        tbLow <= 1'b1;
        @(posedge clock);
        tbLow <= 1'b0;
    endtask : pulseLow
    task printVerdict;
        $display("errors %0d checks %0d", errCount, samplesChecked);
        if (errCount == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : printVerdict
    initial
    begin
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        waitValid;
        check(irqLevels, 16'hFFFF, "defaults");
        foreach (rows[r])
        begin
            {quietEnable, startExtra, frameCount, irq} <= rows[r];
            if (!q) pulseStart;
            waitValid;
            check(irqLevels, {rows[r][15:1], 1'b1}, "levels");
            check({15'h0, quietActive}, {15'h0, rows[r][25]}, "mode");
            q = rows[r][25];
        end
        irq <= 16'h1234;
        pulseLow;
        repeat (30) @(posedge clock);
        check({15'h0, cycleBusy}, 16'h0, "passive");
        quietEnable <= 1'b1;
        pulseStart;
        waitValid;
        pulseLow;
        waitValid;
        check(irqLevels, 16'h1235, "slave start");
        irq <= 16'h0F0F;
        repeat (12) @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        check({14'h0, hOe, quietActive}, 16'h0, "reset");
        nrst <= 1'b1;
        waitValid;
        check(irqLevels, 16'h0F0F, "after reset");
        printVerdict;
    end
    initial
    begin
        #600000;
        errCount++;
        printVerdict;
    end
endmodule : sirq_host_bench
`default_nettype wire
